// ### core/mmt_ctrl.sv
// Management two-wire slave with identification and diagnostic maps, plus
// transmit-disable, fault latch, signal-lost and rate-select control.
// Assumes pins arrive asynchronously; monitors and the id load port are on core_clk.
`timescale 1ns/1ns
`include "mmt_params.svh"
module mmt_ctrl
  import mmt_pkg::*;
(
  input  wire logic        core_clk,            // Core clock, 250 MHz
  input  wire logic        resetn,              // Async reset, active low
  input  wire logic        scl_pin,             // Two-wire clock pin
  input  wire logic        sda_pin,             // Two-wire data pin level
  output logic             sda_drv,             // Data drive value, always low
  output logic             sda_oe,              // Data drive enable
  input  wire logic        tx_off_pin,          // Transmit-off pin
  input  wire logic        rate_sel0_pin,       // Receive rate select pin
  input  wire logic        rate_sel1_pin,       // Transmit rate select pin
  input  wire logic        sig_detect,          // Modulated input present
  input  wire logic        laser_fault_det,     // Laser or eye-safety fault
  input  wire logic [15:0] mon_temp,            // Temperature reading
  input  wire logic [15:0] mon_vcc,             // Supply voltage reading
  input  wire logic [15:0] mon_bias,            // Laser bias reading
  input  wire logic [15:0] mon_txpwr,           // Transmit power reading
  input  wire logic [15:0] mon_rxpwr,           // Receive power reading
  input  wire logic        id_load_en,          // Identification map load strobe
  input  wire logic [7:0]  id_load_addr,        // Identification load offset
  input  wire logic [7:0]  id_load_data,        // Identification load byte
  output logic             laser_en,            // Transmitter enable
  output logic             tx_fault_drv,        // Fault pin drive value, low
  output logic             tx_fault_oe,         // Fault pin pull-down enable
  output logic             receive_signal_lost, // Signal lost output
  output logic             tx_rate_sel,         // Effective transmit rate select
  output logic             rx_rate_sel          // Effective receive rate select
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [`MMT_SY_WIDTH-1:0] raw;
  logic [`MMT_SY_WIDTH-1:0] syn;
  logic scl_s, sda_s, txoff_s, rs0_s, rs1_s, sigdet_s, fault_s;

  assign raw = {laser_fault_det, sig_detect, rate_sel1_pin, rate_sel0_pin,
                tx_off_pin, sda_pin, scl_pin};

  // Transmit-off lane resets high so an undriven pin reads as disabled
  mmt_sync #(.W(`MMT_SY_WIDTH), .RST(`MMT_SYNC_RST)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .d        (raw),
    .q        (syn)
  );

  assign scl_s    = syn[`MMT_SY_SCL];
  assign sda_s    = syn[`MMT_SY_SDA];
  assign txoff_s  = syn[`MMT_SY_TXOFF];
  assign rs0_s    = syn[`MMT_SY_RS0];
  assign rs1_s    = syn[`MMT_SY_RS1];
  assign sigdet_s = syn[`MMT_SY_SIGDET];
  assign fault_s  = syn[`MMT_SY_FAULT];

  // ****************************************
  // Transmitter control
  // ****************************************
  logic scl_q_r, sda_q_r, txoff_q_r, fault_r, laser_en_r, tx_fault_oe_r;
  logic sig_lost_r, tx_rate_r, rx_rate_r;
  logic fault_nxt, laser_en_nxt, off_fall;
  logic soft_dis_r, soft_rxrs_r, soft_txrs_r;

  assign off_fall = txoff_q_r & ~txoff_s;

  always_comb
  begin
    fault_nxt = fault_r;
    if (off_fall)
      fault_nxt = 1'b0;
    // A fault in the clearing cycle still latches
    if (fault_s)
      fault_nxt = 1'b1;
    laser_en_nxt = ~(txoff_s | soft_dis_r | fault_r);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_q_r       <= 1'b1;
      sda_q_r       <= 1'b1;
      txoff_q_r     <= 1'b1;
      fault_r       <= 1'b0;
      laser_en_r    <= 1'b0;
      tx_fault_oe_r <= 1'b1;
      sig_lost_r    <= 1'b1;
      tx_rate_r     <= 1'b0;
      rx_rate_r     <= 1'b0;
    end
    else
    begin
      scl_q_r       <= scl_s;
      sda_q_r       <= sda_s;
      txoff_q_r     <= txoff_s;
      fault_r       <= fault_nxt;
      laser_en_r    <= laser_en_nxt;
      tx_fault_oe_r <= ~fault_r;
      sig_lost_r    <= ~sigdet_s;
      tx_rate_r     <= rs1_s | soft_txrs_r;
      rx_rate_r     <= rs0_s | soft_rxrs_r;
    end
  end

  assign laser_en            = laser_en_r;
  assign tx_fault_oe         = tx_fault_oe_r;
  assign receive_signal_lost = sig_lost_r;
  assign tx_rate_sel         = tx_rate_r;
  assign rx_rate_sel         = rx_rate_r;

  // ****************************************
  // Read data
  // ****************************************
  mmt_state_t st_r, st_nxt;
  mmt_byte_t  sh_r, sh_nxt, ptr_r, ptr_nxt, rd_data, stat;
  mmt_byte_t  id_mem_r [256];
  mmt_byte_t  id_nxt   [256];
  mmt_byte_t  diag_mem_r [256];
  mmt_byte_t  diag_nxt   [256];
  logic [3:0] cnt_r, cnt_nxt;
  logic       sel_diag_r, sel_nxt, rw_r, rw_nxt, oe_r, oe_nxt, sda_o_r, tx_fault_o_r;
  logic       soft_dis_nxt, soft_rxrs_nxt, soft_txrs_nxt, rd_load, stat_wr, wbit6;
  logic       start, stop, scl_rise, scl_fall, dev_hit;

  always_comb
  begin
    stat = {txoff_s, soft_dis_r, rs1_s, rs0_s, soft_rxrs_r, fault_r, sig_lost_r, 1'b0};
    rd_data = id_mem_r[ptr_r];
    if (sel_diag_r)
    begin
      rd_data = diag_mem_r[ptr_r];
      case (ptr_r)
        `MMT_STAT_OFF: rd_data = stat;
        `MMT_EXT_OFF:
        begin
          rd_data = `MMT_BYTE_RST;
          rd_data[`MMT_EXT_TXRS] = soft_txrs_r;
        end
        `MMT_TEMP_HI:  rd_data = mon_temp[15:8];
        `MMT_TEMP_LO:  rd_data = mon_temp[7:0];
        `MMT_VCC_HI:   rd_data = mon_vcc[15:8];
        `MMT_VCC_LO:   rd_data = mon_vcc[7:0];
        `MMT_BIAS_HI:  rd_data = mon_bias[15:8];
        `MMT_BIAS_LO:  rd_data = mon_bias[7:0];
        `MMT_TXPWR_HI: rd_data = mon_txpwr[15:8];
        `MMT_TXPWR_LO: rd_data = mon_txpwr[7:0];
        `MMT_RXPWR_HI: rd_data = mon_rxpwr[15:8];
        `MMT_RXPWR_LO: rd_data = mon_rxpwr[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Two-wire slave and maps
  // ****************************************
  assign start    = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop     = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign dev_hit  = (sh_r[7:1] == `MMT_ID_DEV) || (sh_r[7:1] == `MMT_DIAG_DEV);
  assign wbit6    = sh_r[`MMT_B_SOFTDIS];

  always_comb
  begin
    st_nxt = st_r;  cnt_nxt = cnt_r;  sh_nxt = sh_r;  ptr_nxt = ptr_r;
    sel_nxt = sel_diag_r;  rw_nxt = rw_r;  oe_nxt = oe_r;
    id_nxt = id_mem_r;  diag_nxt = diag_mem_r;
    soft_dis_nxt = soft_dis_r;  soft_rxrs_nxt = soft_rxrs_r;  soft_txrs_nxt = soft_txrs_r;
    rd_load = 1'b0;  stat_wr = 1'b0;
    if (id_load_en)
      id_nxt[id_load_addr] = id_load_data;
    if (start)
    begin
      st_nxt = S_ADDR;  cnt_nxt = 4'h0;  oe_nxt = 1'b0;
    end
    else if (stop)
    begin
      st_nxt = S_IDLE;  oe_nxt = 1'b0;
    end
    else if (scl_rise)
    begin
      unique case (st_r)
        S_ADDR, S_OFFS, S_WRITE:
        begin
          sh_nxt  = {sh_r[6:0], sda_s};
          cnt_nxt = cnt_r + 4'h1;
        end
        S_READ: cnt_nxt = cnt_r + 4'h1;
        // Master not-acknowledge ends the read
        S_RACK: if (sda_s) st_nxt = S_IDLE;
        S_IDLE, S_AACK, S_OACK, S_WACK: ;
        default: st_nxt = S_IDLE;
      endcase
    end
    else if (scl_fall)
    begin
      unique case (st_r)
        S_ADDR:
          if (cnt_r == `MMT_BYTE_BITS)
          begin
            // Foreign addresses get no acknowledge
            st_nxt  = dev_hit ? S_AACK : S_IDLE;
            oe_nxt  = dev_hit;
            sel_nxt = (sh_r[7:1] == `MMT_DIAG_DEV);
            rw_nxt  = sh_r[0];
          end
        S_AACK, S_RACK:
          if (st_r == S_RACK || rw_r)
          begin
            rd_load = 1'b1;  sh_nxt = rd_data;  oe_nxt = ~rd_data[7];
            cnt_nxt = 4'h0;  st_nxt = S_READ;
          end
          else
          begin
            oe_nxt = 1'b0;  cnt_nxt = 4'h0;  st_nxt = S_OFFS;
          end
        S_OFFS:
          if (cnt_r == `MMT_BYTE_BITS)
          begin
            ptr_nxt = sh_r;  oe_nxt = 1'b1;  st_nxt = S_OACK;
          end
        S_OACK, S_WACK:
        begin
          oe_nxt = 1'b0;  cnt_nxt = 4'h0;  st_nxt = S_WRITE;
        end
        S_WRITE:
          if (cnt_r == `MMT_BYTE_BITS)
          begin
            oe_nxt = 1'b1;  st_nxt = S_WACK;  ptr_nxt = ptr_r + 8'h01;
            // Identification writes are acknowledged but not stored
            if (sel_diag_r)
            begin
              if (ptr_r == `MMT_STAT_OFF)
              begin
                stat_wr = 1'b1;
                soft_dis_nxt  = sh_r[`MMT_B_SOFTDIS];
                soft_rxrs_nxt = sh_r[`MMT_B_SOFTRS];
              end
              else if (ptr_r == `MMT_EXT_OFF)
                soft_txrs_nxt = sh_r[`MMT_EXT_TXRS];
              // Monitor bytes are read only
              else if (ptr_r < `MMT_TEMP_HI || ptr_r > `MMT_RXPWR_LO)
                diag_nxt[ptr_r] = sh_r;
            end
          end
        S_READ:
          if (cnt_r == `MMT_BYTE_BITS)
          begin
            oe_nxt = 1'b0;  ptr_nxt = ptr_r + 8'h01;  st_nxt = S_RACK;
          end
          else
          begin
            sh_nxt = {sh_r[6:0], 1'b0};  oe_nxt = ~sh_r[6];
          end
        S_IDLE: ;
        default: st_nxt = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;  sh_r <= `MMT_BYTE_RST;  ptr_r <= `MMT_BYTE_RST;
      sel_diag_r <= 1'b0;  rw_r <= 1'b0;  oe_r <= 1'b0;
      sda_o_r <= 1'b0;  tx_fault_o_r <= 1'b0;
      soft_dis_r <= 1'b0;
      soft_rxrs_r <= 1'b0;  soft_txrs_r <= 1'b0;
      for (int i = 0; i < 256; i++)
      begin
        id_mem_r[i]   <= `MMT_BYTE_RST;
        diag_mem_r[i] <= `MMT_BYTE_RST;
      end
    end
    else
    begin
      st_r <= st_nxt;  cnt_r <= cnt_nxt;  sh_r <= sh_nxt;  ptr_r <= ptr_nxt;
      sel_diag_r <= sel_nxt;  rw_r <= rw_nxt;  oe_r <= oe_nxt;
      sda_o_r <= 1'b0;  tx_fault_o_r <= 1'b0;
      soft_dis_r <= soft_dis_nxt;  soft_rxrs_r <= soft_rxrs_nxt;  soft_txrs_r <= soft_txrs_nxt;
      id_mem_r <= id_nxt;  diag_mem_r <= diag_nxt;
    end
  end

  assign sda_drv      = sda_o_r;
  assign sda_oe       = oe_r;
  assign tx_fault_drv = tx_fault_o_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_off_cycle;
    txoff_s ##1 !txoff_s;
  endsequence
  sequence s_dev_match;
    (st_r == S_ADDR) && scl_fall && !start && !stop && (cnt_r == `MMT_BYTE_BITS) && dev_hit;
  endsequence

  a_laser_off_or: assert property (
    (txoff_s || soft_dis_r || fault_r) |=> !laser_en_r)
    else $error("laser enabled while a disable source is set");
  a_laser_on_clear: assert property (
    !(txoff_s || soft_dis_r || fault_r) |=> laser_en_r)
    else $error("laser stays off with no disable source");
  a_fault_latch_hold: assert property (
    (fault_r && !off_fall) |=> fault_r)
    else $error("fault latch dropped without a disable cycle");
  a_fault_cycle_clr: assert property (
    (s_off_cycle ##0 !fault_s) |=> !fault_r ##1 tx_fault_oe_r)
    else $error("disable cycle did not clear the fault");
  a_fault_pin_drv: assert property (
    fault_r |=> !tx_fault_oe_r)
    else $error("fault pin not released during a fault");
  a_siglost_pin_drv: assert property (
    !sigdet_s |=> sig_lost_r)
    else $error("signal lost not raised without input");
  a_soft_dis_wr: assert property (
    stat_wr |=> soft_dis_r == $past(wbit6))
    else $error("soft disable did not take the written bit");
  a_stat_read: assert property (
    (rd_load && sel_diag_r && ptr_r == `MMT_STAT_OFF) |=>
      (sh_r[7] == $past(txoff_s)) && (sh_r[1] == $past(sig_lost_r)))
    else $error("status byte read does not mirror pin states");
  a_rate_or: assert property (
    (rs0_s || soft_rxrs_r) |=> rx_rate_r)
    else $error("receive rate select ignores a source");
  a_dev_ack: assert property (
    s_dev_match |=> sda_oe && (st_r == S_AACK))
    else $error("matching device address not acknowledged");

endmodule : mmt_ctrl

// ### core/mmt_params.svh
// Constants of the module management and transmit-disable block.
// Assumes inclusion by bare name from the design files that need them.
`ifndef MMT_PARAMS_SVH
`define MMT_PARAMS_SVH

// ****************************************
// Two-wire device addresses (7-bit form of 0xa0 / 0xa2)
// ****************************************
`define MMT_ID_DEV        7'h50
`define MMT_DIAG_DEV      7'h51
`define MMT_BYTE_BITS     4'h8

// ****************************************
// Diagnostic map offsets
// ****************************************
`define MMT_STAT_OFF      8'h6e
`define MMT_EXT_OFF       8'h76
`define MMT_TEMP_HI       8'h60
`define MMT_TEMP_LO       8'h61
`define MMT_VCC_HI        8'h62
`define MMT_VCC_LO        8'h63
`define MMT_BIAS_HI       8'h64
`define MMT_BIAS_LO       8'h65
`define MMT_TXPWR_HI      8'h66
`define MMT_TXPWR_LO      8'h67
`define MMT_RXPWR_HI      8'h68
`define MMT_RXPWR_LO      8'h69

// ****************************************
// Status/control byte fields
// ****************************************
`define MMT_B_TXOFF       7
`define MMT_B_SOFTDIS     6
`define MMT_B_RS1         5
`define MMT_B_RS0         4
`define MMT_B_SOFTRS      3
`define MMT_B_FAULT       2
`define MMT_B_SIGLOST     1
`define MMT_EXT_TXRS      3

// ****************************************
// Synchroniser lanes and their reset levels
// ****************************************
`define MMT_SY_SCL        0
`define MMT_SY_SDA        1
`define MMT_SY_TXOFF      2
`define MMT_SY_RS0        3
`define MMT_SY_RS1        4
`define MMT_SY_SIGDET     5
`define MMT_SY_FAULT      6
`define MMT_SY_WIDTH      7
`define MMT_SYNC_RST      7'h07
`define MMT_BYTE_RST      8'h00

`endif

// ### core/mmt_pkg.sv
// Types shared by the module management block.
// Assumes nothing of its surroundings.
package mmt_pkg;

  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_ADDR  = 9'h002,
    S_AACK  = 9'h004,
    S_OFFS  = 9'h008,
    S_OACK  = 9'h010,
    S_WRITE = 9'h020,
    S_WACK  = 9'h040,
    S_READ  = 9'h080,
    S_RACK  = 9'h100
  } mmt_state_t;

  typedef logic [7:0] mmt_byte_t;

endpackage : mmt_pkg

// ### core/mmt_sync.sv
// Two-flip-flop synchroniser, one lane per bit.
// Assumes each lane is a level from outside the core_clk domain.
`timescale 1ns/1ns
`include "mmt_params.svh"
module mmt_sync
  import mmt_pkg::*;
#(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
)(
  input  wire logic         core_clk, // Core clock
  input  wire logic         resetn,   // Async reset, active low
  input  wire logic [W-1:0] d,        // Asynchronous inputs
  output logic      [W-1:0] q         // Synchronised outputs
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_lane
      logic meta_r;
      logic meta_nxt;
      logic q_nxt;
      always_comb
      begin
        meta_nxt = d[g];
        q_nxt    = meta_r;
      end
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_r <= RST[g];
          q[g]   <= RST[g];
        end
        else
        begin
          meta_r <= meta_nxt;
          q[g]   <= q_nxt;
        end
      end
    end
  endgenerate

endmodule : mmt_sync

// ### dv/mmt_host_model.sv
// Host-side model: two-wire master and transmit-off pin driver.
// Assumes the device samples both pins through its own synchronisers.
`timescale 1ns/1ns
module mmt_host_model
(
  input  wire logic       core_clk, // Pacing clock
  input  wire logic       sda_oe,   // Device pulls data low
  input  wire logic       txd_drv,  // Host drives transmit-off
  input  wire logic       txd_val,  // Level when driven
  output logic            scl,      // Two-wire clock
  output logic            sda,      // Resolved data wire
  output logic            tx_off,   // Resolved transmit-off pin
  output logic            res_stb,  // Result strobe
  output logic [7:0]      res_val   // Acknowledge or read byte
);
  // ****************************************
  // Pins and bus cycles
  // ****************************************
  logic host_oe;

  // Pull-ups: a released line reads high
  assign sda    = ~(host_oe | sda_oe);
  assign tx_off = txd_drv ? txd_val : 1'b1;

  initial
  begin
    scl     = 1'b1;
    host_oe = 1'b0;
    res_stb = 1'b0;
    res_val = 8'h00;
  end

  task automatic hold;
    repeat (8) @(posedge core_clk);
  endtask : hold

  task automatic put(input logic [7:0] v);
    res_val <= v;
    res_stb <= 1'b1;
    @(posedge core_clk);
    res_stb <= 1'b0;
  endtask : put

  // 32 ns phases keep SCL high, low and data setup clear of their minimums
  task automatic bit_io(input logic b, output logic r);
    host_oe <= ~b;
    hold();
    scl <= 1'b1;
    hold();
    r = sda;
    scl <= 1'b0;
    hold();
  endtask : bit_io

  // Also serves as repeated start: data released before SCL rises
  task automatic start;
    host_oe <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    host_oe <= 1'b1;
    hold();
    scl <= 1'b0;
    hold();
  endtask : start

  task automatic stop;
    host_oe <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    host_oe <= 1'b0;
    hold();
  endtask : stop

  task automatic wr_byte(input logic [7:0] b);
    logic [7:0] r;
    logic       a;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r[i]);
    bit_io(1'b1, a);
    put({7'h00, ~a});
  endtask : wr_byte

  task automatic rd_byte(input logic last);
    logic [7:0] r;
    logic       a;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, r[i]);
    bit_io(last, a);
    put(r);
  endtask : rd_byte
endmodule : mmt_host_model

// ### dv/test_mmt_ctrl.sv
// Self-checking bench for the management and transmit-disable block.
// Assumes the host model owns the two-wire and transmit-off pins.
`timescale 1ns/1ns
module test_mmt_ctrl;
  // ****************************************
  // Stimulus, checking and verdict
  // ****************************************
  logic        core_clk, resetn, rate0, rate1, sig_det, fault_det, txd_drv, txd_val;
  logic        scl, sda, tx_off, sda_o, sda_oe, res_stb, snap, id_en;
  logic        laser_en, flt_o, flt_oe, sig_lost, tx_rs, rx_rs;
  logic [7:0]  res_val, id_addr, id_data;
  logic [15:0] mon [5];
  logic [7:0]  exp_q[$];
  logic [6:0]  pin_q[$];
  logic [7:0]  d[$];
  logic [7:0]  idv [3];
  logic [7:0]  ia [3] = '{8'hff, 8'h00, 8'h80};
  logic [3:0]  rt [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
  int          err_count, samples_checked;

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  mmt_host_model host
  (
    .core_clk, .sda_oe, .txd_drv, .txd_val, .scl, .sda, .tx_off, .res_stb, .res_val
  );

  mmt_ctrl dut
  (
    .core_clk, .resetn, .scl_pin(scl), .sda_pin(sda), .sda_drv(sda_o), .sda_oe,
    .tx_off_pin(tx_off),
    .rate_sel0_pin(rate0), .rate_sel1_pin(rate1), .sig_detect(sig_det),
    .laser_fault_det(fault_det), .mon_temp(mon[0]), .mon_vcc(mon[1]), .mon_bias(mon[2]),
    .mon_txpwr(mon[3]), .mon_rxpwr(mon[4]), .id_load_en(id_en), .id_load_addr(id_addr),
    .id_load_data(id_data), .laser_en, .tx_fault_drv(flt_o), .tx_fault_oe(flt_oe),
    .receive_signal_lost(sig_lost), .tx_rate_sel(tx_rs), .rx_rate_sel(rx_rs)
  );

  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected byte at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_pins(input logic [6:0] e, input logic [6:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected pins at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp_pins

  always @(posedge core_clk)
  begin
    if (res_stb === 1'b1)
      cmp_byte(exp_q.pop_front(), res_val);
    if (snap === 1'b1)
      cmp_pins(pin_q.pop_front(),
               {laser_en, flt_oe, sig_lost, tx_rs, rx_rs, flt_o, sda_o});
  end

  task automatic wt;
    repeat (8) @(posedge core_clk);
  endtask : wt

  // Pin order: laser on, fault pin pulled low, signal lost, tx rate, rx rate
  // Both open-drain drive values must always read zero
  task automatic chk(input logic [4:0] e);
    pin_q.push_back({e, 2'b00});
    snap <= 1'b1;
    @(posedge core_clk);
    snap <= 1'b0;
  endtask : chk

  task automatic rst;
    resetn <= 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    wt();
    wt();
  endtask : rst

  task automatic wr(input logic [7:0] dev, input logic [7:0] off, input logic [7:0] dat);
    host.start();
    repeat (3) exp_q.push_back(8'h01);
    host.wr_byte(dev);
    host.wr_byte(off);
    host.wr_byte(dat);
    host.stop();
  endtask : wr

  task automatic rd(input logic [7:0] dev, input logic [7:0] off, input logic [7:0] e[$]);
    host.start();
    repeat (3) exp_q.push_back(8'h01);
    foreach (e[i])
      exp_q.push_back(e[i]);
    host.wr_byte(dev);
    host.wr_byte(off);
    host.start();
    host.wr_byte(dev | 8'h01);
    foreach (e[i])
      host.rd_byte(i == e.size() - 1);
    host.stop();
  endtask : rd

  function automatic logic [7:0] stat(input logic sd, input logic rxs, input logic fl);
    return {tx_off, sd, rate1, rate0, rxs, fl, ~sig_det, 1'b0};
  endfunction : stat

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    conclude();
  end

  initial
  begin
    {rate0, rate1, fault_det, txd_drv, snap, id_en, resetn} = '0;
    {sig_det, txd_val} = 2'b11;
    {id_addr, id_data} = 16'h0000;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(16863));
    foreach (mon[i])
      mon[i] = 16'($urandom());
    rst();
    chk(5'b01000);
    d = {stat(1'b0, 1'b0, 1'b0)};
    rd(8'ha2, 8'h6e, d);
    txd_drv <= 1'b1;
    txd_val <= 1'b0;
    wt();
    chk(5'b11000);
    wr(8'ha2, 8'h6e, 8'h40);
    wt();
    chk(5'b01000);
    // Ones written to read-only status bits must not stick
    foreach (rt[i])
    begin
      {rate1, rate0} <= rt[i][1:0];
      wr(8'ha2, 8'h6e, {4'hf, rt[i][2], 3'h7});
      wr(8'ha2, 8'h76, {4'h0, rt[i][3], 3'h0});
      wt();
      chk({3'b010, rt[i][1] | rt[i][3], rt[i][0] | rt[i][2]});
      d = {stat(1'b1, rt[i][2], 1'b0)};
      rd(8'ha2, 8'h6e, d);
    end
    d = {};
    foreach (mon[i])
    begin
      d.push_back(mon[i][15:8]);
      d.push_back(mon[i][7:0]);
    end
    rd(8'ha2, 8'h60, d);
    foreach (idv[i])
    begin
      idv[i] = 8'($urandom());
      id_en   <= 1'b1;
      id_addr <= ia[i];
      id_data <= idv[i];
      @(posedge core_clk);
    end
    id_en <= 1'b0;
    wr(8'ha0, 8'h80, ~idv[2]);
    wr(8'ha2, 8'h80, ~idv[2]);
    d = {idv[0], idv[1]};
    rd(8'ha0, 8'hff, d);
    d = {idv[2]};
    rd(8'ha0, 8'h80, d);
    d = {~idv[2]};
    rd(8'ha2, 8'h80, d);
    host.start();
    exp_q.push_back(8'h00);
    host.wr_byte(8'ha4);
    host.stop();
    wr(8'ha2, 8'h6e, 8'h00);
    wt();
    chk(5'b11000);
    fault_det <= 1'b1;
    wt();
    fault_det <= 1'b0;
    wt();
    chk(5'b00000);
    d = {stat(1'b0, 1'b0, 1'b1)};
    rd(8'ha2, 8'h6e, d);
    txd_val <= 1'b1;
    wt();
    chk(5'b00000);
    txd_val <= 1'b0;
    wt();
    chk(5'b11000);
    sig_det <= 1'b0;
    wt();
    chk(5'b11100);
    d = {stat(1'b0, 1'b0, 1'b0)};
    rd(8'ha2, 8'h6e, d);
    wr(8'ha2, 8'h6e, 8'h40);
    rst();
    chk(5'b11100);
    d = {stat(1'b0, 1'b0, 1'b0)};
    rd(8'ha2, 8'h6e, d);
    conclude();
  end
endmodule : test_mmt_ctrl
